// *** design/iopfc_pkg.sv ***
`default_nettype none
package iopfc_pkg;
    // frame geometry
    localparam int FRAME_BITS = 16;
    localparam int PIN_COUNT = 8;
    // control word fields
    localparam int KIND_BIT = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 11;
    localparam int DATA_MSB = 10;
    localparam int SEL_MSB = 7;
    localparam logic KIND_CONTROL = 1'h0;
    // control addresses
    localparam logic [3:0] ADDR_GEN_CTRL = 4'h3;
    localparam logic [3:0] ADDR_AIN_SEL = 4'h4;
    localparam logic [3:0] ADDR_AOUT_SEL = 4'h5;
    localparam logic [3:0] ADDR_PULLDN_SEL = 4'h6;
    localparam logic [3:0] ADDR_DOUT_SEL = 4'h8;
    localparam logic [3:0] ADDR_DIN_SEL = 4'ha;
    localparam logic [3:0] ADDR_ODRAIN_SEL = 4'hc;
    localparam logic [3:0] ADDR_TRISTATE_SEL = 4'hd;
    // general control bit positions
    localparam int GC_PRECHARGE = 9;
    localparam int GC_BUF_EN = 8;
    localparam int GC_LOCK = 7;
    localparam int GC_BROADCAST = 6;
    localparam int GC_ADC_RANGE = 5;
    localparam int GC_DAC_RANGE = 4;
    // reset values
    localparam logic [10:0] GEN_CTRL_RESET = 11'h000;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] PULLDN_RESET = 8'hff;
    // pin function encoding
    localparam logic [2:0] FN_PULLDN = 3'h0;
    localparam logic [2:0] FN_AIN = 3'h1;
    localparam logic [2:0] FN_AOUT = 3'h2;
    localparam logic [2:0] FN_AOUT_AIN = 3'h3;
    localparam logic [2:0] FN_DOUT = 3'h4;
    localparam logic [2:0] FN_DIN = 3'h5;
    localparam logic [2:0] FN_DOUT_DIN = 3'h6;
    localparam logic [2:0] FN_TRISTATE = 3'h7;
endpackage
`default_nettype wire

// *** design/iopfc_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module iopfc_top #(
    parameter int PINS = 8 // number of multi-function pins
) (
    input wire logic sys_clk, // system clock, 100 MHz
    input wire logic reset_n, // async reset, active low
    input wire logic clkEn, // clock enable, freezes state when low
    input wire logic linkClk, // serial link clock pin
    input wire logic linkSelN, // frame select pin, active low
    input wire logic linkDataIn, // serial data in pin
    input wire logic convBusy, // converter busy level, same domain
    output logic [PINS-1:0] pinSelectAin, // analog input select register
    output logic [PINS-1:0] pinSelectAout, // analog output select register
    output logic [PINS-1:0] pinSelectPulldn, // pull-down select register
    output logic [PINS-1:0] pinSelectDout, // digital output select register
    output logic [PINS-1:0] pinSelectDin, // digital input select register
    output logic [PINS-1:0] pinSelectOdrain, // open-drain select register
    output logic [PINS-1:0] pinSelectTristate, // three-state select register
    output logic [3*PINS-1:0] pinFunction, // resolved function per pin
    output logic [PINS-1:0] pinDriveOpenDrain, // output pins drive open-drain
    output logic [PINS-1:0] pinSampleEnable, // input path may sample pin
    output logic [10:0] generalControl, // general control register
    output logic adcBufferPower, // input buffer powered
    output logic adcRangeDouble, // input range twice reference
    output logic dacRangeDouble, // output range twice reference
    output logic broadcastOutputWrite, // converter writes go to all outputs
    output logic [15:0] dacWord, // last converter data word
    output logic dacWordValid // one-cycle pulse per converter word
);
    // the select data field is one byte, so no other pin count can be served
    if (PINS != iopfc_pkg::PIN_COUNT)
    begin : gPinCountCheck
        $error("iopfc_top supports exactly eight pins");
    end

    // pin synchronisers; first stage feeds only the second
    // the link clock is sampled like data; its edges are found below
    logic [2:0] syncA_q;
    logic [2:0] syncB_q;
    logic linkClkPrev_q; // delayed link clock for edge find
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // idle levels, so no false link clock edge follows reset
            syncA_q <= 3'h7;
            syncB_q <= 3'h7;
            linkClkPrev_q <= 1'h1;
        end
        else if (clkEn)
        begin
            syncA_q <= {linkClk, linkSelN, linkDataIn};
            syncB_q <= syncA_q;
            linkClkPrev_q <= syncB_q[2];
        end
    end

    logic clkS; // synced link clock
    logic selS; // synced frame select
    logic datS; // synced data
    assign clkS = syncB_q[2];
    assign selS = syncB_q[1];
    assign datS = syncB_q[0];
    // two cycles of pin latency; each link clock half needs three sys_clk cycles
    logic fallEdge; // data is taken on link clock falling edge
    assign fallEdge = linkClkPrev_q & ~clkS;

    // shift register and bit count; link clock 80 ns leaves 4 cycles/half
    logic [15:0] shift_q;
    logic [4:0] bitCount_q;
    logic selPrev_q;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            shift_q <= 16'h0000;
            bitCount_q <= 5'h00;
            selPrev_q <= 1'h1;
        end
        else if (clkEn)
        begin
            selPrev_q <= selS;
            if (selS)
            begin
                bitCount_q <= 5'h00; // frame idle: restart count
            end
            // bits past the sixteenth are dropped, so a long frame acts on its first 16 bits
            else if (fallEdge && bitCount_q != 5'h10)
            begin
                shift_q <= {shift_q[14:0], datS};
                bitCount_q <= bitCount_q + 5'h01;
            end
        end
    end

    // word acted on only when select rises after a full 16 bits
    // short frames fail the count and are dropped silently; long frames keep their first 16 bits
    logic frameDone;
    assign frameDone = selS & ~selPrev_q & (bitCount_q == 5'h10);
    logic isControl;
    assign isControl = shift_q[iopfc_pkg::KIND_BIT] == iopfc_pkg::KIND_CONTROL;
    logic [3:0] addr;
    assign addr = shift_q[iopfc_pkg::ADDR_MSB:iopfc_pkg::ADDR_LSB];
    logic [7:0] selData;
    assign selData = shift_q[iopfc_pkg::SEL_MSB:0];
    logic locked;
    assign locked = generalControl[iopfc_pkg::GC_LOCK];
    logic ctrlWrite;
    assign ctrlWrite = frameDone & isControl;
    // lock gates the pin selects only; the general register stays writable
    logic selWrite; // pin select write allowed
    assign selWrite = ctrlWrite & ~locked;

    // general control register, writable even when locked
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            generalControl <= iopfc_pkg::GEN_CTRL_RESET;
        end
        else if (clkEn && ctrlWrite && addr == iopfc_pkg::ADDR_GEN_CTRL)
        begin
            // lock bit is stored here too, so unlocking needs this path open
            // reserved bits stored as written; host keeps them zero
            generalControl <= shift_q[iopfc_pkg::DATA_MSB:0];
        end
    end

    // pin select registers; writes of 1 assign function
    // full byte stored; the function follows the last 1 written
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pinSelectAin <= iopfc_pkg::SEL_RESET;
            pinSelectAout <= iopfc_pkg::SEL_RESET;
            pinSelectPulldn <= iopfc_pkg::PULLDN_RESET;
            pinSelectDout <= iopfc_pkg::SEL_RESET;
            pinSelectDin <= iopfc_pkg::SEL_RESET;
            pinSelectOdrain <= iopfc_pkg::SEL_RESET;
            pinSelectTristate <= iopfc_pkg::SEL_RESET;
        end
        else if (clkEn && selWrite)
        begin
            // decode of the four address bits
            if (addr == iopfc_pkg::ADDR_AIN_SEL)
            begin
                pinSelectAin <= selData;
            end
            else if (addr == iopfc_pkg::ADDR_AOUT_SEL)
            begin
                pinSelectAout <= selData;
            end
            else if (addr == iopfc_pkg::ADDR_PULLDN_SEL)
            begin
                pinSelectPulldn <= selData;
            end
            else if (addr == iopfc_pkg::ADDR_DOUT_SEL)
            begin
                pinSelectDout <= selData;
            end
            else if (addr == iopfc_pkg::ADDR_DIN_SEL)
            begin
                pinSelectDin <= selData;
            end
            else if (addr == iopfc_pkg::ADDR_ODRAIN_SEL)
            begin
                pinSelectOdrain <= selData;
            end
            else if (addr == iopfc_pkg::ADDR_TRISTATE_SEL)
            begin
                pinSelectTristate <= selData;
            end
            // other addresses fall through and change nothing
        end
    end

    // per-pin function resolution, last write wins, except that an input and an output write of one kind give the dual function
    genvar g;
    generate
        for (g = 0; g < PINS; g = g + 1)
        begin : gPin
            logic [2:0] fn; // function this pin holds now
            logic bit1; // written bit for this pin
            assign fn = pinFunction[3*g+2:3*g];
            assign bit1 = selData[g];
            // a written 0 leaves the pin's function as it was
            always_ff @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    pinFunction[3*g+2:3*g] <= iopfc_pkg::FN_PULLDN;
                end
                else if (clkEn && selWrite && bit1)
                begin
                    if (addr == iopfc_pkg::ADDR_AIN_SEL)
                    begin
                        // dual analog keeps output primary
                        if (fn == iopfc_pkg::FN_AOUT || fn == iopfc_pkg::FN_AOUT_AIN)
                        begin
                            pinFunction[3*g+2:3*g] <= iopfc_pkg::FN_AOUT_AIN;
                        end
                        else
                        begin
                            pinFunction[3*g+2:3*g] <= iopfc_pkg::FN_AIN;
                        end
                    end
                    else if (addr == iopfc_pkg::ADDR_AOUT_SEL)
                    begin
                        if (fn == iopfc_pkg::FN_AIN || fn == iopfc_pkg::FN_AOUT_AIN)
                        begin
                            pinFunction[3*g+2:3*g] <= iopfc_pkg::FN_AOUT_AIN;
                        end
                        else
                        begin
                            pinFunction[3*g+2:3*g] <= iopfc_pkg::FN_AOUT;
                        end
                    end
                    else if (addr == iopfc_pkg::ADDR_DOUT_SEL)
                    begin
                        // dual digital keeps output primary
                        if (fn == iopfc_pkg::FN_DIN || fn == iopfc_pkg::FN_DOUT_DIN)
                        begin
                            pinFunction[3*g+2:3*g] <= iopfc_pkg::FN_DOUT_DIN;
                        end
                        else
                        begin
                            pinFunction[3*g+2:3*g] <= iopfc_pkg::FN_DOUT;
                        end
                    end
                    else if (addr == iopfc_pkg::ADDR_DIN_SEL)
                    begin
                        if (fn == iopfc_pkg::FN_DOUT || fn == iopfc_pkg::FN_DOUT_DIN)
                        begin
                            pinFunction[3*g+2:3*g] <= iopfc_pkg::FN_DOUT_DIN;
                        end
                        else
                        begin
                            pinFunction[3*g+2:3*g] <= iopfc_pkg::FN_DIN;
                        end
                    end
                    else if (addr == iopfc_pkg::ADDR_PULLDN_SEL)
                    begin
                        pinFunction[3*g+2:3*g] <= iopfc_pkg::FN_PULLDN;
                    end
                    else if (addr == iopfc_pkg::ADDR_TRISTATE_SEL)
                    begin
                        pinFunction[3*g+2:3*g] <= iopfc_pkg::FN_TRISTATE;
                    end
                    // open-drain select changes drive style only
                end
            end

            // drive style and sampling path follow the function
            // recomputed every cycle, so a later function change takes effect
            always_ff @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    pinDriveOpenDrain[g] <= 1'h0;
                    pinSampleEnable[g] <= 1'h0;
                end
                else if (clkEn)
                begin
                    pinDriveOpenDrain[g] <= pinSelectOdrain[g] &
                        (pinFunction[3*g+2:3*g] == iopfc_pkg::FN_DOUT ||
                         pinFunction[3*g+2:3*g] == iopfc_pkg::FN_DOUT_DIN);
                    pinSampleEnable[g] <=
                        pinFunction[3*g+2:3*g] == iopfc_pkg::FN_AIN ||
                        pinFunction[3*g+2:3*g] == iopfc_pkg::FN_AOUT_AIN ||
                        pinFunction[3*g+2:3*g] == iopfc_pkg::FN_DIN ||
                        pinFunction[3*g+2:3*g] == iopfc_pkg::FN_DOUT_DIN;
                end
            end
        end
    endgenerate

    // general control decode into plain levels
    // convBusy is same-domain logic, so it needs no synchroniser
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            adcBufferPower <= 1'h0;
            adcRangeDouble <= 1'h0;
            dacRangeDouble <= 1'h0;
            broadcastOutputWrite <= 1'h0;
        end
        else if (clkEn)
        begin
            // precharge mode: buffer only while converting
            adcBufferPower <= generalControl[iopfc_pkg::GC_BUF_EN] &
                (~generalControl[iopfc_pkg::GC_PRECHARGE] | convBusy);
            adcRangeDouble <= generalControl[iopfc_pkg::GC_ADC_RANGE];
            dacRangeDouble <= generalControl[iopfc_pkg::GC_DAC_RANGE];
            broadcastOutputWrite <= generalControl[iopfc_pkg::GC_BROADCAST];
        end
    end

    // converter data words handed on; broadcast flag tells consumer
    // channel fan-out for broadcast writes lives downstream of this block
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dacWord <= 16'h0000;
            dacWordValid <= 1'h0;
        end
        else if (clkEn)
        begin
            dacWordValid <= frameDone & ~isControl;
            if (frameDone && !isControl)
            begin
                dacWord <= shift_q;
            end
        end
    end
endmodule // iopfc_top
`default_nettype wire

// *** tb/iopfc_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module iopfc_props #(
    parameter int PINS = 8 // pin count
) (
    input wire logic sys_clk, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic linkSelN, // frame select pin
    input wire logic convBusy, // conversion running
    input wire logic [PINS-1:0] pinSelectAin, // analog in select
    input wire logic [PINS-1:0] pinSelectAout, // analog out select
    input wire logic [PINS-1:0] pinSelectPulldn, // pull-down select
    input wire logic [PINS-1:0] pinSelectDout, // digital out select
    input wire logic [PINS-1:0] pinSelectDin, // digital in select
    input wire logic [PINS-1:0] pinSelectOdrain, // open-drain select
    input wire logic [PINS-1:0] pinSelectTristate, // three-state select
    input wire logic [3*PINS-1:0] pinFunction, // resolved functions
    input wire logic [PINS-1:0] pinDriveOpenDrain, // open-drain drive
    input wire logic [10:0] generalControl, // general control
    input wire logic adcBufferPower, // input buffer powered
    input wire logic adcRangeDouble, // input range doubled
    input wire logic dacRangeDouble, // output range doubled
    input wire logic broadcastOutputWrite, // broadcast mode
    input wire logic [15:0] dacWord, // last converter word
    input wire logic dacWordValid // converter word pulse
);
    logic [6*PINS-1:0] fnSel; // selects that may move a pin's function
    logic [PINS-1:0] doutMask; // pins whose function drives digitally
    assign fnSel = {pinSelectAin, pinSelectAout, pinSelectPulldn,
                    pinSelectDout, pinSelectDin, pinSelectTristate};
    // decode from the resolved function, not the raw selects, since selects overlap
    always_comb
    begin
        for (int g = 0; g < PINS; g++)
        begin
            doutMask[g] = pinFunction[3*g+:3] inside {3'h4, 3'h6};
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    property p_reset_state;
        $rose(reset_n) |-> pinSelectPulldn == {PINS{1'b1}} && pinFunction == '0
            && generalControl == 11'h000;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("state after reset wrong");
    property p_lock_holds;
        generalControl[7] && $past(generalControl[7]) |-> $stable({fnSel, pinSelectOdrain});
    endproperty
    a_lock_holds: assert property (p_lock_holds)
        else $error("pin select changed while locked");
    property p_odrain;
        1'b1 |=> pinDriveOpenDrain == $past(pinSelectOdrain & doutMask);
    endproperty
    a_odrain: assert property (p_odrain)
        else $error("open-drain drive wrong");
    property p_buffer;
        1'b1 |=> adcBufferPower ==
            $past(generalControl[8] && (!generalControl[9] || convBusy));
    endproperty
    a_buffer: assert property (p_buffer)
        else $error("buffer power wrong");
    property p_ranges;
        1'b1 |=> {adcRangeDouble, dacRangeDouble, broadcastOutputWrite} ==
            $past({generalControl[5], generalControl[4], generalControl[6]});
    endproperty
    a_ranges: assert property (p_ranges)
        else $error("range or broadcast output wrong");
    property p_frame_end;
        !$stable({fnSel, pinSelectOdrain, generalControl}) |-> linkSelN && $past(linkSelN, 3);
    endproperty
    a_frame_end: assert property (p_frame_end)
        else $error("register changed inside a frame");
    property p_dac_pulse;
        dacWordValid |-> dacWord[15] ##1 !dacWordValid;
    endproperty
    a_dac_pulse: assert property (p_dac_pulse)
        else $error("converter word pulse wrong");
    property p_fn_cause;
        !$stable(pinFunction) |-> linkSelN && !$past(generalControl[7]);
    endproperty
    a_fn_cause: assert property (p_fn_cause)
        else $error("function moved inside a frame or while locked");
endmodule // iopfc_props
bind iopfc_top iopfc_props #(.PINS(PINS)) u_props (
    .sys_clk(sys_clk), .reset_n(reset_n), .linkSelN(linkSelN), .convBusy(convBusy),
    .pinSelectAin(pinSelectAin), .pinSelectAout(pinSelectAout),
    .pinSelectPulldn(pinSelectPulldn), .pinSelectDout(pinSelectDout),
    .pinSelectDin(pinSelectDin), .pinSelectOdrain(pinSelectOdrain),
    .pinSelectTristate(pinSelectTristate), .pinFunction(pinFunction),
    .pinDriveOpenDrain(pinDriveOpenDrain), .generalControl(generalControl),
    .adcBufferPower(adcBufferPower), .adcRangeDouble(adcRangeDouble),
    .dacRangeDouble(dacRangeDouble), .broadcastOutputWrite(broadcastOutputWrite),
    .dacWord(dacWord), .dacWordValid(dacWordValid));
`default_nettype wire

// *** tb/iopfc_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module iopfc_host (
    input wire logic sysClk, // system clock
    output logic linkClk, // link clock, stands high between frames
    output logic linkSelN, // frame select, active low
    output logic linkDataIn // serial data, msb first
);
    // idle link at time zero
    initial
    begin
        linkClk = 1'b1;
        linkSelN = 1'b1;
        linkDataIn = 1'b1;
    end
    // one frame of n bits; 4 cycles a half period gives the 80 ns link clock
    task automatic send(input logic [15:0] w, input int n);
        @(posedge sysClk);
        linkSelN <= 1'b0;
        for (int i = 15; i > 15 - n; i--)
        begin
            linkDataIn <= w[i]; // set while clock is high
            repeat (4) @(posedge sysClk);
            linkClk <= 1'b0; // device takes the bit here
            repeat (4) @(posedge sysClk);
            linkClk <= 1'b1;
        end
        repeat (2) @(posedge sysClk);
        linkSelN <= 1'b1;
        linkDataIn <= ~linkDataIn; // released line must not show the last bit
        repeat (10) @(posedge sysClk); // gap lets the update land
    endtask
endmodule // iopfc_host
`default_nettype wire

// *** tb/io_pin_function_config_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin nFail++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module io_pin_function_config_test;
    logic sysClk = 1'b0; // 100 MHz
    logic resetN = 1'b0; // reset, active low
    logic clkEn = 1'b1; // state enabled except in the clock enable test
    logic convBusy = 1'b0; // converter idle unless a test says so
    wire logic linkClk, linkSelN, linkDataIn; // link from the host model
    logic [7:0] pinSelectAin, pinSelectAout, pinSelectPulldn; // select regs
    logic [7:0] pinDriveOpenDrain, pinSampleEnable; // derived pin controls
    logic [23:0] pinFunction; // resolved functions
    logic [10:0] generalControl; // general control
    logic [7:0] pinSelectDout, pinSelectDin, pinSelectOdrain, pinSelectTristate; // more selects
    wire logic [3:0] gcOut; // buffer, broadcast, input range, output range
    logic [15:0] dacWord; // converter word
    wire logic dacWordValid; // converter word pulse
    int nPulse = 0; // converter word pulses seen
    int nTests = 0; // comparisons made
    int nFail = 0; // mismatches seen
    // rows: address, data, function nibble per pin, expected open-drain drive
    logic [51:0] rows [10] = '{
        {4'h4, 8'h03, 32'h00000011, 8'h00}, {4'h5, 8'h0c, 32'h00002211, 8'h00},
        {4'h8, 8'h10, 32'h00042211, 8'h00}, {4'ha, 8'h20, 32'h00542211, 8'h00},
        {4'hd, 8'hc0, 32'h77542211, 8'h00}, {4'h4, 8'h04, 32'h77542311, 8'h00},
        {4'ha, 8'h10, 32'h77562311, 8'h00}, {4'hc, 8'h10, 32'h77562311, 8'h10},
        {4'h6, 8'h01, 32'h77562310, 8'h10}, {4'h8, 8'h02, 32'h77562340, 8'h10}};
    iopfc_top dut (
        .sys_clk(sysClk), .reset_n(resetN), .clkEn(clkEn), .linkClk(linkClk),
        .linkSelN(linkSelN), .linkDataIn(linkDataIn), .convBusy(convBusy),
        .pinSelectAin(pinSelectAin), .pinSelectAout(pinSelectAout),
        .pinSelectPulldn(pinSelectPulldn), .pinSelectDout(pinSelectDout),
        .pinSelectDin(pinSelectDin), .pinSelectOdrain(pinSelectOdrain),
        .pinSelectTristate(pinSelectTristate), .pinFunction(pinFunction),
        .pinDriveOpenDrain(pinDriveOpenDrain), .pinSampleEnable(pinSampleEnable),
        .generalControl(generalControl), .adcBufferPower(gcOut[3]),
        .adcRangeDouble(gcOut[1]), .dacRangeDouble(gcOut[0]),
        .broadcastOutputWrite(gcOut[2]), .dacWord(dacWord), .dacWordValid(dacWordValid));
    iopfc_host host (.sysClk(sysClk), .linkClk(linkClk), .linkSelN(linkSelN),
        .linkDataIn(linkDataIn));
    // pin-select write; reserved bits 10..8 always zero
    function automatic logic [15:0] cw(input logic [3:0] a, input logic [7:0] d);
        return {iopfc_pkg::KIND_CONTROL, a, 3'h0, d};
    endfunction
    // expand one nibble per pin into the 3-bit packed function field
    function automatic logic [23:0] fn24(input logic [31:0] n);
        logic [23:0] r;
        for (int g = 0; g < 8; g++)
        begin
            r[3*g+:3] = n[4*g+:3];
        end
        return r;
    endfunction
    // single exit point for pass, fail and hang
    task automatic endSim;
        $display("checks %0d mismatches %0d", nTests, nFail);
        if (nFail == 0 && nTests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // count converter word pulses; each stands one cycle and is seen once
    always @(posedge sysClk)
    begin
        if (dacWordValid)
            nPulse <= nPulse + 1;
    end
    // free-running system clock
    initial
    begin
        forever #5 sysClk = ~sysClk;
    end
    // cut a hang short
    initial
    begin
        repeat (20000) @(posedge sysClk);
        nFail++;
        $display("unexpected timeout exp %h got %h", 1'b0, 1'b1);
        endSim();
    end
    // main sequence; converter idle around pin writes, lock clear except in the lock test
    initial
    begin
        repeat (3) @(posedge sysClk);
        resetN <= 1'b1;
        repeat (4) @(posedge sysClk);
        for (int r = 0; r < 10; r++)
        begin
            host.send(cw(rows[r][51:48], rows[r][47:40]), 16);
            `CHK("pinFunction", fn24(rows[r][39:8]), pinFunction)
            `CHK("pinDriveOpenDrain", rows[r][7:0], pinDriveOpenDrain)
        end
        `CHK("pinSampleEnable", 8'h34, pinSampleEnable)
        `CHK("pinSelectAin", 8'h04, pinSelectAin)
        `CHK("pinSelectPulldn", 8'h01, pinSelectPulldn)
        `CHK("pinSelectDout", 8'h02, pinSelectDout)
        `CHK("pinSelectDin", 8'h10, pinSelectDin)
        `CHK("pinSelectOdrain", 8'h10, pinSelectOdrain)
        `CHK("pinSelectTristate", 8'hc0, pinSelectTristate)
        $display("test table done");
        host.send({5'h03, 11'h170}, 16);
        `CHK("generalControl", 11'h170, generalControl)
        `CHK("gcOut", 4'hf, gcOut)
        host.send({5'h03, 11'h300}, 16);
        `CHK("gcOut", 4'h0, gcOut)
        convBusy <= 1'b1;
        repeat (3) @(posedge sysClk);
        `CHK("gcOut", 4'h8, gcOut)
        convBusy <= 1'b0;
        $display("test general control done");
        host.send({5'h03, 11'h080}, 16);
        host.send(cw(4'h4, 8'hff), 16);
        `CHK("pinSelectAin", 8'h04, pinSelectAin)
        `CHK("pinFunction", fn24(32'h77562340), pinFunction)
        host.send({5'h03, 11'h000}, 16);
        `CHK("generalControl", 11'h000, generalControl)
        host.send(cw(4'h4, 8'h80), 16);
        `CHK("pinFunction", fn24(32'h17562340), pinFunction)
        $display("test lock done");
        host.send(cw(4'h5, 8'hff), 15);
        host.send(cw(4'he, 8'hff), 16);
        `CHK("pinSelectAout", 8'h0c, pinSelectAout)
        `CHK("pinFunction", fn24(32'h17562340), pinFunction)
        host.send(16'h8abc, 16);
        `CHK("dacWord", 16'h8abc, dacWord)
        `CHK("generalControl", 11'h000, generalControl)
        `CHK("dacWordValid pulses", 1, nPulse)
        $display("test refused frames done");
        clkEn <= 1'b0;
        host.send(cw(4'h4, 8'h01), 16);
        clkEn <= 1'b1;
        repeat (8) @(posedge sysClk);
        `CHK("pinSelectAin", 8'h80, pinSelectAin)
        $display("test clock enable done");
        resetN <= 1'b0;
        repeat (3) @(posedge sysClk);
        resetN <= 1'b1;
        @(posedge sysClk);
        `CHK("pinSelectPulldn", 8'hff, pinSelectPulldn)
        `CHK("pinFunction", 24'h000000, pinFunction)
        `CHK("pinSelectAin", 8'h00, pinSelectAin)
        $display("test second reset done");
        endSim();
    end
endmodule // io_pin_function_config_test
`default_nettype wire
